/* tpwm_pkg.sv */
// Package for the 16-bit timer PWM waveform generator.
// Assumes AXI4-Lite register access with 32-bit data, byte offsets below.
package tpwm_pkg;

  // Register byte offsets
  localparam logic [7:0] TPWM_CTRL_OFF    = 8'h00;
  localparam logic [7:0] TPWM_COUNT_OFF   = 8'h04;
  localparam logic [7:0] TPWM_CMPA_OFF    = 8'h08;
  localparam logic [7:0] TPWM_CMPB_OFF    = 8'h0c;
  localparam logic [7:0] TPWM_CAPT_OFF    = 8'h10;
  localparam logic [7:0] TPWM_FLAGS_OFF   = 8'h14;
  localparam logic [7:0] TPWM_PINEN_OFF   = 8'h18;
  localparam logic [7:0] TPWM_PINDIR_OFF  = 8'h1c;

  // Control register field positions
  localparam int TPWM_WGM_LSB   = 0;   // waveform_mode_select 3:0
  localparam int TPWM_CS_LSB    = 4;   // prescaler select 6:4
  localparam int TPWM_OMA_LSB   = 8;   // out_mode_a 9:8
  localparam int TPWM_OMB_LSB   = 10;  // out_mode_b 11:10

  // Flag bit positions
  localparam int TPWM_FLG_OVF   = 0;
  localparam int TPWM_FLG_CMPA  = 1;
  localparam int TPWM_FLG_CMPB  = 2;
  localparam int TPWM_FLG_CAPT  = 3;

  // Pin enable fields
  localparam int TPWM_PINA_LSB  = 0;
  localparam int TPWM_PINB_LSB  = 4;

  // Reset values and counter extremes
  localparam logic [15:0] TPWM_BOTTOM   = 16'h0000;
  localparam logic [15:0] TPWM_MAX      = 16'hffff;
  localparam logic [15:0] TPWM_TOP8     = 16'h00ff;
  localparam logic [15:0] TPWM_TOP9     = 16'h01ff;
  localparam logic [15:0] TPWM_TOP10    = 16'h03ff;
  localparam logic [31:0] TPWM_ZERO32   = 32'h0000_0000;

  // Prescaler divisors
  localparam logic [9:0] TPWM_DIV8     = 10'd7;
  localparam logic [9:0] TPWM_DIV64    = 10'd63;
  localparam logic [9:0] TPWM_DIV256   = 10'd255;
  localparam logic [9:0] TPWM_DIV1024  = 10'd1023;

  // AXI responses
  localparam logic [1:0] TPWM_RESP_OK     = 2'b00;
  localparam logic [1:0] TPWM_RESP_SLVERR = 2'b10;

  // Compare output mode encodings
  typedef enum logic [1:0] {
    TPWM_OM_OFF    = 2'd0,
    TPWM_OM_TOGGLE = 2'd1,
    TPWM_OM_NONINV = 2'd2,
    TPWM_OM_INV    = 2'd3
  } tpwm_om_t;

  // Waveform family derived from mode select
  typedef enum logic [1:0] {
    TPWM_FAM_NORMAL = 2'd0,
    TPWM_FAM_FAST   = 2'd1,
    TPWM_FAM_PC     = 2'd3,
    TPWM_FAM_PFC    = 2'd2
  } tpwm_fam_t;

  // Pin group carrying one channel's pin outputs
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } tpwm_pins_t;

endpackage

/* tpwm_gen.sv */
// PWM waveform generator of a 16-bit timer with AXI4-Lite registers.
// Assumes one 40 MHz clock, synchronous active-low reset, no interrupts.
//
// Notes on behaviour
// - Capture TOP unbuffered; missed TOP wraps via MAX
// - Compare A buffered, loads at TOP in fast
// - Out mode two non-inverted, three inverted
// - Pin driven only with direction and enable
// - Fast: action at match, opposite at TOP
// - Prescaler divides by 1,8,64,256,1024
// - Fast: BOTTOM spike, TOP constant level
// - Fast mode 1 toggles A on match
// - Modes 1,2,3,10,11 are phase correct
// - Phase correct: clear up, set down
// - TOP fixed 8/9/10/16 bits or register
// - Freq correct: load and overflow at BOTTOM
// - Register TOP sets its flag at TOP
// - Freq correct: action up, opposite down
// - Dual slope: BOTTOM low, TOP high
// - Fast mode 1 needs top mode bit set
// - Compare equal TOP acts at TOP only
// - Pin enables: A bits 3:0, B 7:4
`timescale 1ns/100ps
`default_nettype none
module tpwm_gen
  import tpwm_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Waveforms and pins
  output logic                    wave_out_a,
  output logic                    wave_out_b,
  output tpwm_pkg::tpwm_pins_t    pins_a,
  output tpwm_pkg::tpwm_pins_t    pins_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] ctrl_q;
  logic [15:0] counter_value_q;
  logic [15:0] compare_reg_a_q, compare_buf_a_q;
  logic [15:0] compare_reg_b_q, compare_buf_b_q;
  logic [15:0] capture_top_reg_q;
  logic [3:0]  flags_q;
  logic [7:0]  pin_enable_reg_q;
  logic [1:0]  pin_direction_bit_q;
  logic        count_down_q;
  logic [9:0]  presc_q;

  logic [3:0]  waveform_mode_select;
  logic        waveform_mode_top_bit;
  logic [2:0]  clk_sel;
  tpwm_om_t    out_mode_a, out_mode_b;
  assign waveform_mode_select  = ctrl_q[TPWM_WGM_LSB +: 4];
  assign waveform_mode_top_bit = waveform_mode_select[3];
  assign clk_sel    = ctrl_q[TPWM_CS_LSB +: 3];
  assign out_mode_a = tpwm_om_t'(ctrl_q[TPWM_OMA_LSB +: 2]);
  assign out_mode_b = tpwm_om_t'(ctrl_q[TPWM_OMB_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  // Family of a mode value, following the usual 16-bit timer table
  function automatic tpwm_fam_t mode_family(input logic [3:0] m);
    case (m)
      4'd1, 4'd2, 4'd3, 4'd10, 4'd11: mode_family = TPWM_FAM_PC;
      4'd8, 4'd9:                      mode_family = TPWM_FAM_PFC;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15:  mode_family = TPWM_FAM_FAST;
      default:                         mode_family = TPWM_FAM_NORMAL;
    endcase
  endfunction

  tpwm_fam_t   fam;
  logic [15:0] top;
  logic        top_is_capt, top_is_cmpa, pwm_mode;
  assign fam      = mode_family(waveform_mode_select);
  assign pwm_mode = (fam != TPWM_FAM_NORMAL);

  // TOP source: fixed widths, capture register or compare A
  always_comb begin
    top_is_capt = 1'b0;
    top_is_cmpa = 1'b0;
    case (waveform_mode_select)
      4'd1, 4'd5:   top = TPWM_TOP8;
      4'd2, 4'd6:   top = TPWM_TOP9;
      4'd3, 4'd7:   top = TPWM_TOP10;
      4'd8, 4'd10, 4'd12, 4'd14: begin
        top = capture_top_reg_q;
        top_is_capt = 1'b1;
      end
      4'd4, 4'd9, 4'd11, 4'd15: begin
        top = compare_reg_a_q;
        top_is_cmpa = 1'b1;
      end
      default:      top = TPWM_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: one-cycle timer tick
  logic tick;
  always_comb begin
    case (clk_sel)
      3'd1:    tick = 1'b1;
      3'd2:    tick = (presc_q[2:0] == TPWM_DIV8[2:0]);
      3'd3:    tick = (presc_q[5:0] == TPWM_DIV64[5:0]);
      3'd4:    tick = (presc_q[7:0] == TPWM_DIV256[7:0]);
      3'd5:    tick = (presc_q == TPWM_DIV1024);
      default: tick = 1'b0;  // Stopped
    endcase
  end

  // Free-running divider; select zero holds it at zero
  always_ff @(posedge aclk) begin
    if (!aresetn || clk_sel == 3'd0) begin
      presc_q <= 10'd0;
    end else begin
      presc_q <= presc_q + 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter events
  logic at_top, at_bottom, dual, cnt_wr;
  assign dual      = (fam == TPWM_FAM_PC) || (fam == TPWM_FAM_PFC);
  assign at_top    = (counter_value_q == top);
  assign at_bottom = (counter_value_q == TPWM_BOTTOM);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_q && w_q && !s_axi_bvalid;

  // Write channels held until both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= TPWM_ZERO32;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q     <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q     <= 1'b0;
      end
    end
  end

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic wr_known;
  always_comb begin
    if (awaddr_q == TPWM_CTRL_OFF || awaddr_q == TPWM_COUNT_OFF ||
        awaddr_q == TPWM_CMPA_OFF || awaddr_q == TPWM_CMPB_OFF ||
        awaddr_q == TPWM_CAPT_OFF || awaddr_q == TPWM_FLAGS_OFF ||
        awaddr_q == TPWM_PINEN_OFF || awaddr_q == TPWM_PINDIR_OFF) begin
      wr_known = 1'b1;
    end else begin
      wr_known = 1'b0;
    end
  end
  assign cnt_wr = wr_go && (awaddr_q == TPWM_COUNT_OFF);

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TPWM_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? TPWM_RESP_OK : TPWM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q              <= 16'h0000;
      capture_top_reg_q   <= 16'h0000;
      pin_enable_reg_q    <= 8'h00;
      pin_direction_bit_q <= 2'b00;
    end else if (wr_go) begin
      if (awaddr_q == TPWM_CTRL_OFF) begin
        ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q);
      end else if (awaddr_q == TPWM_CAPT_OFF) begin
        capture_top_reg_q <= merge16(capture_top_reg_q, wdata_q, wstrb_q);
      end else if (awaddr_q == TPWM_PINEN_OFF && wstrb_q[0]) begin
        pin_enable_reg_q <= wdata_q[7:0];
      end else if (awaddr_q == TPWM_PINDIR_OFF && wstrb_q[0]) begin
        pin_direction_bit_q <= wdata_q[1:0];
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= TPWM_ZERO32;
      s_axi_rresp  <= TPWM_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= TPWM_RESP_OK;
      // Reads of compare registers return the buffered value
      if (s_axi_araddr == TPWM_CTRL_OFF) begin
        s_axi_rdata <= {16'h0000, ctrl_q};
      end else if (s_axi_araddr == TPWM_COUNT_OFF) begin
        s_axi_rdata <= {16'h0000, counter_value_q};
      end else if (s_axi_araddr == TPWM_CMPA_OFF) begin
        s_axi_rdata <= {16'h0000, compare_buf_a_q};
      end else if (s_axi_araddr == TPWM_CMPB_OFF) begin
        s_axi_rdata <= {16'h0000, compare_buf_b_q};
      end else if (s_axi_araddr == TPWM_CAPT_OFF) begin
        s_axi_rdata <= {16'h0000, capture_top_reg_q};
      end else if (s_axi_araddr == TPWM_FLAGS_OFF) begin
        s_axi_rdata <= {28'h0000000, flags_q};
      end else if (s_axi_araddr == TPWM_PINEN_OFF) begin
        s_axi_rdata <= {24'h000000, pin_enable_reg_q};
      end else if (s_axi_araddr == TPWM_PINDIR_OFF) begin
        s_axi_rdata <= {30'h00000000, pin_direction_bit_q};
      end else begin
        s_axi_rdata <= TPWM_ZERO32;
        s_axi_rresp <= TPWM_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  // A write of the counter blocks the next tick's compare match
  logic blk_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value_q <= TPWM_BOTTOM;
      count_down_q    <= 1'b0;
      blk_q           <= 1'b0;
    end else if (cnt_wr) begin
      counter_value_q <= merge16(counter_value_q, wdata_q, wstrb_q);
      blk_q           <= 1'b1;
    end else if (tick) begin
      blk_q <= 1'b0;
      if (dual) begin
        // Up to TOP then down to BOTTOM
        if (at_top) begin
          count_down_q    <= 1'b1;
          counter_value_q <= counter_value_q - 16'd1;
        end else if (at_bottom) begin
          count_down_q    <= 1'b0;
          counter_value_q <= counter_value_q + 16'd1;
        end else if (count_down_q) begin
          counter_value_q <= counter_value_q - 16'd1;
        end else begin
          counter_value_q <= counter_value_q + 16'd1;
        end
      end else if (at_top) begin
        counter_value_q <= TPWM_BOTTOM;
        count_down_q    <= 1'b0;
      end else begin
        // Above an unbuffered TOP it runs on through MAX and wraps
        counter_value_q <= counter_value_q + 16'd1;
        count_down_q    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Double-buffered compare registers
  logic load_now;
  always_comb begin
    case (fam)
      TPWM_FAM_FAST: load_now = tick && at_top;
      TPWM_FAM_PFC:  load_now = tick && at_bottom;
      TPWM_FAM_PC:   load_now = tick && at_top;
      default:       load_now = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_buf_a_q <= 16'h0000;
      compare_buf_b_q <= 16'h0000;
      compare_reg_a_q <= 16'h0000;
      compare_reg_b_q <= 16'h0000;
    end else begin
      if (wr_go && awaddr_q == TPWM_CMPA_OFF) begin
        compare_buf_a_q <= merge16(compare_buf_a_q, wdata_q, wstrb_q);
      end
      if (wr_go && awaddr_q == TPWM_CMPB_OFF) begin
        compare_buf_b_q <= merge16(compare_buf_b_q, wdata_q, wstrb_q);
      end
      // Non-PWM modes copy straight through
      if (load_now || !pwm_mode) begin
        compare_reg_a_q <= compare_buf_a_q;
        compare_reg_b_q <= compare_buf_b_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, write one to clear; a set in the same cycle wins
  logic match_a, match_b;
  assign match_a = tick && !blk_q && (counter_value_q == compare_reg_a_q);
  assign match_b = tick && !blk_q && (counter_value_q == compare_reg_b_q);

  logic [3:0] flag_set, flag_clr;
  always_comb begin
    flag_set = 4'h0;
    flag_set[TPWM_FLG_OVF] = tick && ((fam == TPWM_FAM_PFC || fam == TPWM_FAM_PC)
                              ? at_bottom : at_top);
    flag_set[TPWM_FLG_CMPA] = match_a || (tick && at_top && top_is_cmpa);
    flag_set[TPWM_FLG_CMPB] = match_b;
    flag_set[TPWM_FLG_CAPT] = tick && at_top && top_is_capt;
    flag_clr = (wr_go && awaddr_q == TPWM_FLAGS_OFF && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform update per channel
  function automatic logic wave_next(input logic      cur,
                                     input tpwm_om_t  om,
                                     input tpwm_fam_t f,
                                     input logic      hit,
                                     input logic      t_top,
                                     input logic      down,
                                     input logic      is_a,
                                     input logic      top_bit);
    logic act;
    act = (om == TPWM_OM_INV);  // Level set by a match when counting up
    wave_next = cur;
    case (f)
      TPWM_FAM_FAST: begin
        if (om == TPWM_OM_TOGGLE) begin
          if (hit && is_a && top_bit) wave_next = !cur;
        end else if (om[1]) begin
          // A match at TOP is dropped, so the TOP action alone decides
          if (t_top) wave_next = !act;
          else if (hit) wave_next = act;
        end
      end
      TPWM_FAM_PC, TPWM_FAM_PFC: begin
        if (om[1] && hit) wave_next = down ? !act : act;
      end
      default: begin
        if (hit) begin
          case (om)
            TPWM_OM_TOGGLE: wave_next = !cur;
            TPWM_OM_NONINV: wave_next = 1'b0;
            TPWM_OM_INV:    wave_next = 1'b1;
            default:        wave_next = cur;
          endcase
        end
      end
    endcase
  endfunction

  // Extremes belong to the slope being entered: BOTTOM holds low, TOP high
  logic slope_down;
  assign slope_down = at_top ? 1'b1 : (at_bottom ? 1'b0 : count_down_q);
  logic hit_a, hit_b, ta_top, tb_top;
  // In fast PWM with out mode two or three, a compare equal to TOP is served at TOP, not as a match
  assign ta_top = (compare_reg_a_q == top);
  assign tb_top = (compare_reg_b_q == top);
  assign hit_a  = match_a && !(fam == TPWM_FAM_FAST && ta_top && out_mode_a[1]);
  assign hit_b  = match_b && !(fam == TPWM_FAM_FAST && tb_top && out_mode_b[1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else if (tick) begin
      wave_out_a <= wave_next(wave_out_a, out_mode_a, fam, hit_a, at_top,
                              slope_down, 1'b1, waveform_mode_top_bit);
      wave_out_b <= wave_next(wave_out_b, out_mode_b, fam, hit_b, at_top,
                              slope_down, 1'b0, waveform_mode_top_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing: drive only with direction, enable and a connected mode
  logic con_a, con_b;
  assign con_a = (out_mode_a != TPWM_OM_OFF) &&
                 !(fam == TPWM_FAM_FAST && out_mode_a == TPWM_OM_TOGGLE &&
                   !waveform_mode_top_bit);
  assign con_b = (out_mode_b != TPWM_OM_OFF) &&
                 !(fam == TPWM_FAM_FAST && out_mode_b == TPWM_OM_TOGGLE);
  assign pins_a.out = {4{wave_out_a}};
  assign pins_b.out = {4{wave_out_b}};
  assign pins_a.oe  = pin_enable_reg_q[TPWM_PINA_LSB +: 4] &
                      {4{pin_direction_bit_q[0] && con_a}};
  assign pins_b.oe  = pin_enable_reg_q[TPWM_PINB_LSB +: 4] &
                      {4{pin_direction_bit_q[1] && con_b}};

endmodule
`default_nettype wire

/* tpwm_gen_monitor.sv */
// Checker for the PWM generator: bus answers and pin copies.
// Bound to tpwm_gen from the testbench; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module tpwm_gen_monitor
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Bus handshakes
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  // Waves and pins
  input wire logic                 wave_out_a,
  input wire logic                 wave_out_b,
  input wire tpwm_pkg::tpwm_pins_t pins_a,
  input wire tpwm_pkg::tpwm_pins_t pins_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Each pin group copies its wave level
  property p_pin_a; pins_a.out == {4{wave_out_a}}; endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a level");
  property p_pin_b; pins_b.out == {4{wave_out_b}}; endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b level");
  // Write answers two edges after both halves are taken, read one edge after
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  // Pending answers refuse new requests
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write not refused");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read not refused");
  // Registers are at most 16 bits; unmapped reads give zero
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits");
  property p_rd_err;
    s_axi_rvalid && s_axi_rresp == TPWM_RESP_SLVERR |-> s_axi_rdata == TPWM_ZERO32;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("error read data");
endmodule
`default_nettype wire

/* tpwm_load.sv */
// Load model: pulled-up port pins behind the generator.
// Assumes pin groups straight from the generator.
`timescale 1ns/100ps
`default_nettype none
module tpwm_load
  import tpwm_pkg::*;
(
  // Pin groups from the generator
  input  wire tpwm_pkg::tpwm_pins_t pins_a,
  input  wire tpwm_pkg::tpwm_pins_t pins_b,
  // Levels on the pins
  output logic [3:0]                lvl_a,
  output logic [3:0]                lvl_b
);
  // Undriven pins rest at the pull-up level
  assign lvl_a = pins_a.oe & pins_a.out | ~pins_a.oe;
  assign lvl_b = pins_b.oe & pins_b.out | ~pins_b.oe;
endmodule
`default_nettype wire

/* tpwm_gen_test.sv */
// Testbench for the PWM generator: duty, period, pins, flags.
// Assumes the design, checker and load model compiled first.
`timescale 1ns/100ps
`default_nettype none
module tpwm_gen_test;
  import tpwm_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, wave_out_a, wave_out_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, lvl_a, lvl_b;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  tpwm_pins_t  pins_a, pins_b;
  int          n_errors, n_checks, seed, m, o, j, t;
  int          dv[6] = '{0, 1, 8, 64, 256, 1024};
  tpwm_gen tpwm_gen_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_out_a, .wave_out_b, .pins_a, .pins_b);
  tpwm_load tpwm_load_i (.pins_a, .pins_b, .lvl_a, .lvl_b);
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input int d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (k = 0; k < 50 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid); k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (k = 0; k < 50 && (s_axi_arvalid || !s_axi_rvalid); k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
    @(posedge aclk);
  endtask
  // Stop, load TOP and compares, restart; waiting lets the buffers load
  task automatic setup(input int wgm, cs, oa, ob, tp, c);
    wr(TPWM_CTRL_OFF, 0);
    wr(TPWM_COUNT_OFF, 0);
    wr(TPWM_CAPT_OFF, tp);
    wr(TPWM_CMPA_OFF, c);
    wr(TPWM_CMPB_OFF, c);
    wr(TPWM_CTRL_OFF, wgm | cs << 4 | oa << 8 | ob << 10);
    repeat (4 * (tp + 1) * dv[cs]) @(posedge aclk);
  endtask
  // High cycles over a window; X on a wave spoils the sum
  task automatic meas(input int n, ea, eb);
    logic [31:0] ha, hb;
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge aclk);
      ha = ha + 32'(wave_out_a);
      hb = hb + 32'(wave_out_b);
    end
    check(ha, ea, "high cycles a");
    if (eb >= 0) check(hb, eb, "high cycles b");
  endtask
  // High ticks a period: fast sets at BOTTOM, dual slope mirrors at match
  function automatic int exp_hi(input int ds, om, c, tp);
    int h;
    h = ds ? 2 * c : c + 1;
    return om == 3 ? (ds ? 2 * tp : tp + 1) - h : h;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    seed = 39;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // All registers clear; the word past the map answers with an error
    for (j = 0; j < 9; j++) begin
      rd(8'(4 * j));
      check(rv, 0, "reset value");
      if (j == 8) check(rs, TPWM_RESP_SLVERR, "read resp");
    end
    wr(8'h20, 1);
    check(rs, TPWM_RESP_SLVERR, "write resp");
    en = 8'($random(seed));
    wr(TPWM_PINEN_OFF, en);
    wr(TPWM_PINDIR_OFF, 1);
    // Fast, phase correct, freq correct; both polarities; extreme and random compares
    for (m = 0; m < 3; m++)
      for (o = 2; o < 4; o++)
        for (j = 0; j < 3; j++) begin
          t = 3 + $unsigned($random(seed)) % 8;
          o = o;
          setup(m == 0 ? 14 : m == 1 ? 10 : 8, 1, o, o, t,
                j == 0 ? 0 : j == 1 ? t : $unsigned($random(seed)) % t);
          rd(TPWM_CMPA_OFF);
          meas(m == 0 ? t + 1 : 2 * t, exp_hi(m, o, rv, t), exp_hi(m, o, rv, t));
        end
    check(pins_a.oe, en[3:0], "oe a");
    check(lvl_b, 4'hf, "idle pin b");
    // Each prescaler step stretches the period
    for (j = 2; j < 6; j++) begin
      setup(14, j, 2, 2, 3, 1);
      meas(4 * dv[j], 2 * dv[j], 2 * dv[j]);
    end
    rd(TPWM_FLAGS_OFF);
    check(rv & 32'h9, 32'h9, "top flags");
    // Toggle with compare A as TOP; mode 5 leaves the pins disconnected
    wr(TPWM_PINDIR_OFF, 2);
    setup(15, 1, 1, 2, 6, 6);
    meas(14, 7, -1);
    check(pins_b.oe, en[7:4], "oe b");
    rd(TPWM_FLAGS_OFF);
    check(rv[1], 1, "compare a flag");
    wr(TPWM_PINDIR_OFF, 3);
    setup(5, 1, 1, 1, 3, 1);
    check(pins_a.oe, 0, "oe off");
    check(pins_b.oe, 0, "oe b off");
    complete_run();
  end
endmodule
bind tpwm_gen tpwm_gen_monitor tpwm_gen_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .wave_out_a, .wave_out_b,
  .pins_a, .pins_b);
`default_nettype wire
